// ---- src/sdsr_defines.vh ----
// constants of the stepper driver status register bank
`ifndef SDSR_DEFINES_VH
`define SDSR_DEFINES_VH
`define SDSR_ADDR_W 3
`define SDSR_ADDR_LIVE 3'h4
`define SDSR_ADDR_XOVC 3'h5
`define SDSR_ADDR_YOVC 3'h6
`define SDSR_ADDR_POS 3'h7
`define SDSR_RESET_VAL 8'h00
`define SDSR_POS_RESET 7'h00
`define SDSR_BIT_CHECK 7
`define SDSR_BIT_WARN 6
`define SDSR_BIT_CP 5
`define SDSR_BIT_WDOG 4
`define SDSR_BIT_OPX 3
`define SDSR_BIT_OPY 2
`define SDSR_BIT_SHUT 2
`endif

// ---- src/sdsr_ovc_latch.v ----
// sticky flag group: set by a live condition, cleared by a read
`timescale 1ns/1ps
module sdsr_ovc_latch #(
  parameter WIDTH = 4
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] cond_i,
  input wire clear_i,
  output reg [WIDTH-1:0] flags_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          flags_o[g] <= 1'b0;
        end else if (cond_i[g]) begin
          // set wins over the read clear so no event is lost
          flags_o[g] <= 1'b1;
        end else if (clear_i) begin
          flags_o[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // sdsr_ovc_latch

// ---- src/sdsr_status_regs.v ----
// status register bank of the stepper driver, read by the serial master
// How it works
// - four read-only registers, latched flags zero after reset
// - 0x04 live: check, warning, pump, watchdog, opens
// - 0x05 latched X-bridge overcurrent flags
// - 0x06 latched Y-bridge overcurrent, thermal shutdown
// - 0x07 live micro-step position field
// - check bit in every register msb
// - watchdog flag set on missed timer clear
// - watchdog flag survives watchdog-caused reset
// - watchdog flag cleared by writing enable zero
// - pump fault flag follows pump voltage failure
// - open coil flags follow open detection
// - X overcurrent flag set on detection
// - Y overcurrent flag set on detection
// - seven-bit position, passed through live, not reset
`timescale 1ns/1ps
`include "sdsr_defines.vh"
module sdsr_status_regs (
  input wire SYS_CLK_I,
  input wire RST_B_I,
  input wire THERMAL_WARNING_FLAG_I,
  input wire THERMAL_SHUTDOWN_FLAG_I,
  input wire CHARGE_PUMP_FAULT_I,
  input wire WATCHDOG_TIMEOUT_I,
  input wire WATCHDOG_ENABLE_WR_I,
  input wire WATCHDOG_ENABLE_BIT_I,
  input wire COIL_X_OPEN_FLAG_I,
  input wire COIL_Y_OPEN_FLAG_I,
  input wire [3:0] X_OVERCURRENT_I,
  input wire [3:0] Y_OVERCURRENT_I,
  input wire [6:0] MICROSTEP_POSITION_I,
  input wire RD_I,
  input wire [2:0] ADDR_I,
  output reg [7:0] RDATA_O,
  output reg RVALID_O,
  output wire WATCHDOG_EVENT_FLAG_O
);

  localparam NUM_REGS = 4;
  localparam BODY_W = 7;
  localparam OVC_W = 4;

  reg watchdog_event_flag;
  reg next_watchdog_event_flag;
  wire watchdog_clear_req;
  wire watchdog_set_req;

  reg [7:0] next_rdata;
  wire rd_x;
  wire rd_y;
  wire rd_mapped;
  wire [1:0] rd_index;

  wire [OVC_W-1:0] x_flags;
  wire [OVC_W:0] y_tsd;
  wire [OVC_W-1:0] y_flags;

  // live fields
  wire thermal_warning_flag;
  wire charge_pump_fault;
  wire coil_x_open_flag;
  wire coil_y_open_flag;
  wire [BODY_W-1:0] microstep_position;

  // latched fields
  wire x_pos_top_overcurrent;
  wire x_pos_bottom_overcurrent;
  wire x_neg_top_overcurrent;
  wire x_neg_bottom_overcurrent;
  wire y_pos_top_overcurrent;
  wire y_pos_bottom_overcurrent;
  wire y_neg_top_overcurrent;
  wire y_neg_bottom_overcurrent;
  wire thermal_shutdown_flag;

  // register bodies, bit positions as in the finished byte
  reg [BODY_W-1:0] live_body;
  reg [BODY_W-1:0] x_body;
  reg [BODY_W-1:0] y_body;

  // index 0 holds the register at 0x04, index 3 the one at 0x07
  wire [BODY_W-1:0] status_byte_body [0:NUM_REGS-1];
  wire [7:0] status_byte [0:NUM_REGS-1];

  // even count of ones across the whole byte
  function [7:0] with_check;
    input [BODY_W-1:0] body;
    begin
      with_check = {^body, body};
    end
  endfunction

  function hits;
    input [`SDSR_ADDR_W-1:0] addr;
    input [`SDSR_ADDR_W-1:0] target;
    begin
      hits = (addr == target);
    end
  endfunction

  // the bank sits in the upper half of the address space
  function is_mapped;
    input [`SDSR_ADDR_W-1:0] addr;
    begin
      is_mapped = hits(addr, `SDSR_ADDR_LIVE) ||
                  hits(addr, `SDSR_ADDR_XOVC) ||
                  hits(addr, `SDSR_ADDR_YOVC) ||
                  hits(addr, `SDSR_ADDR_POS);
    end
  endfunction

  // the watchdog reset of the device must not reach this flop; of the resets,
  // only the power-on / hard reset RST_B_I clears it
  assign watchdog_clear_req = WATCHDOG_ENABLE_WR_I &&
                              !WATCHDOG_ENABLE_BIT_I;
  assign watchdog_set_req = WATCHDOG_TIMEOUT_I;

  // a timeout in the clearing cycle wins, so no expiry goes unseen
  always @* begin
    next_watchdog_event_flag = watchdog_event_flag;
    if (watchdog_clear_req) begin
      next_watchdog_event_flag = 1'b0;
    end
    if (watchdog_set_req) begin
      next_watchdog_event_flag = 1'b1;
    end
  end

  always @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      watchdog_event_flag <= 1'b0;
    end else begin
      watchdog_event_flag <= next_watchdog_event_flag;
    end
  end

  assign WATCHDOG_EVENT_FLAG_O = watchdog_event_flag;

  assign thermal_warning_flag = THERMAL_WARNING_FLAG_I;
  assign charge_pump_fault = CHARGE_PUMP_FAULT_I;
  assign coil_x_open_flag = COIL_X_OPEN_FLAG_I;
  assign coil_y_open_flag = COIL_Y_OPEN_FLAG_I;
  assign microstep_position = MICROSTEP_POSITION_I;

  assign rd_x = RD_I && hits(ADDR_I, `SDSR_ADDR_XOVC);
  assign rd_y = RD_I && hits(ADDR_I, `SDSR_ADDR_YOVC);
  assign rd_mapped = is_mapped(ADDR_I);
  assign rd_index = ADDR_I[1:0];

  // order: pos-top, pos-bottom, neg-top, neg-bottom from msb down
  sdsr_ovc_latch #(
    .WIDTH(OVC_W)
  ) u_x_latch (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .cond_i(X_OVERCURRENT_I),
    .clear_i(rd_x),
    .flags_o(x_flags)
  );

  // thermal shutdown shares the Y group's read clear
  sdsr_ovc_latch #(
    .WIDTH(OVC_W + 1)
  ) u_y_latch (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .cond_i({Y_OVERCURRENT_I, THERMAL_SHUTDOWN_FLAG_I}),
    .clear_i(rd_y),
    .flags_o(y_tsd)
  );

  assign x_pos_top_overcurrent = x_flags[3];
  assign x_pos_bottom_overcurrent = x_flags[2];
  assign x_neg_top_overcurrent = x_flags[1];
  assign x_neg_bottom_overcurrent = x_flags[0];
  assign y_flags = y_tsd[OVC_W:1];
  assign y_pos_top_overcurrent = y_flags[3];
  assign y_pos_bottom_overcurrent = y_flags[2];
  assign y_neg_top_overcurrent = y_flags[1];
  assign y_neg_bottom_overcurrent = y_flags[0];
  assign thermal_shutdown_flag = y_tsd[0];

  always @* begin
    live_body = {BODY_W{1'b0}};
    live_body[`SDSR_BIT_WARN] = thermal_warning_flag;
    live_body[`SDSR_BIT_CP] = charge_pump_fault;
    live_body[`SDSR_BIT_WDOG] = watchdog_event_flag;
    live_body[`SDSR_BIT_OPX] = coil_x_open_flag;
    live_body[`SDSR_BIT_OPY] = coil_y_open_flag;
  end

  always @* begin
    x_body = {BODY_W{1'b0}};
    x_body[6] = x_pos_top_overcurrent;
    x_body[5] = x_pos_bottom_overcurrent;
    x_body[4] = x_neg_top_overcurrent;
    x_body[3] = x_neg_bottom_overcurrent;
  end

  always @* begin
    y_body = {BODY_W{1'b0}};
    y_body[6] = y_pos_top_overcurrent;
    y_body[5] = y_pos_bottom_overcurrent;
    y_body[4] = y_neg_top_overcurrent;
    y_body[3] = y_neg_bottom_overcurrent;
    y_body[`SDSR_BIT_SHUT] = thermal_shutdown_flag;
  end

  assign status_byte_body[0] = live_body;
  assign status_byte_body[1] = x_body;
  assign status_byte_body[2] = y_body;
  assign status_byte_body[3] = microstep_position;

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : g_check
      assign status_byte[g] = with_check(status_byte_body[g]);
    end
  endgenerate

  // unmapped addresses read as zero; the snapshot is taken in the same
  // cycle the latched group clears, so the master sees the set value
  always @* begin
    next_rdata = `SDSR_RESET_VAL;
    if (rd_mapped) begin
      next_rdata = status_byte[rd_index];
    end
  end

  always @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= RD_I;
    end
  end

  always @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= `SDSR_RESET_VAL;
    end else if (RD_I) begin
      RDATA_O <= next_rdata;
    end
  end
endmodule // sdsr_status_regs

// ---- tb/sdsr_master.sv ----
// master model: single status reads
`timescale 1ns/1ps
module sdsr_master(input clk_i, rvalid_i, input [7:0] rdata_i,
  output reg rd_o = 0, output reg [2:0] addr_o = 0);
  task rd(input [2:0] a, output [7:0] d);
    @(negedge clk_i) {rd_o, addr_o} = {1'b1, a};
    // a released address must not keep its old value
    @(negedge clk_i) {rd_o, addr_o} = {1'b0, ~a};
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask
endmodule // sdsr_master

// ---- tb/sdsr_status_regs_chk.sv ----
// read side and watchdog flag assertions of the status bank
`timescale 1ns/1ps
module sdsr_chk(input SYS_CLK_I, RST_B_I, RD_I, RVALID_O,
  input WATCHDOG_TIMEOUT_I, WATCHDOG_ENABLE_WR_I, WATCHDOG_ENABLE_BIT_I,
  input WATCHDOG_EVENT_FLAG_O, input [2:0] ADDR_I, input [7:0] RDATA_O);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence s_rd(a); RD_I && ADDR_I == a; endsequence
  property p_rv; RD_I |=> RVALID_O; endproperty
  a_rv: assert property (p_rv) else $error("rv");
  property p_nv; !RD_I |=> !RVALID_O; endproperty
  a_nv: assert property (p_nv) else $error("nv");
  property p_pa; RVALID_O |-> !(^RDATA_O); endproperty
  a_pa: assert property (p_pa) else $error("pa");
  property p_st; !RD_I |=> $stable(RDATA_O); endproperty
  a_st: assert property (p_st) else $error("st");
  property p_lo; RD_I && !ADDR_I[2] |=> RDATA_O == 8'h00; endproperty
  a_lo: assert property (p_lo) else $error("lo");
  property p_b0; s_rd(4) |=> RDATA_O[1:0] == 2'h0; endproperty
  a_b0: assert property (p_b0) else $error("b0");
  property p_b1; s_rd(5) |=> RDATA_O[2:0] == 3'h0; endproperty
  a_b1: assert property (p_b1) else $error("b1");
  property p_b2; s_rd(6) |=> RDATA_O[1:0] == 2'h0; endproperty
  a_b2: assert property (p_b2) else $error("b2");
  property p_wd; WATCHDOG_TIMEOUT_I |=> WATCHDOG_EVENT_FLAG_O; endproperty
  a_wd: assert property (p_wd) else $error("wd set");
  property p_wk;
    WATCHDOG_EVENT_FLAG_O && !(WATCHDOG_ENABLE_WR_I && !WATCHDOG_ENABLE_BIT_I)
      |=> WATCHDOG_EVENT_FLAG_O;
  endproperty
  a_wk: assert property (p_wk) else $error("wd kept");
endmodule // sdsr_chk
bind sdsr_status_regs sdsr_chk u_sdsr_chk(.*);

// ---- tb/sdsr_status_regs_tb.sv ----
// bench for the status register bank
`timescale 1ns/1ps
module sdsr_status_regs_tb;
  reg c = 0, r = 0, wt = 0, wr = 0, wb = 0;
  wire wf;
  reg [19:0] f = 0;
  reg [7:0] d;
  wire rd, rv;
  wire [2:0] ad;
  wire [7:0] q;
  integer num_errors = 0, total_checks = 0, i;
  always #10 c = ~c;
  sdsr_status_regs u_sdsr_status_regs(.SYS_CLK_I(c), .RST_B_I(r),
    .THERMAL_WARNING_FLAG_I(f[19]), .CHARGE_PUMP_FAULT_I(f[18]),
    .COIL_X_OPEN_FLAG_I(f[17]), .COIL_Y_OPEN_FLAG_I(f[16]),
    .MICROSTEP_POSITION_I(f[15:9]), .X_OVERCURRENT_I(f[8:5]),
    .Y_OVERCURRENT_I(f[4:1]), .THERMAL_SHUTDOWN_FLAG_I(f[0]),
    .WATCHDOG_TIMEOUT_I(wt), .WATCHDOG_ENABLE_WR_I(wr),
    .WATCHDOG_ENABLE_BIT_I(wb), .RD_I(rd), .ADDR_I(ad), .RDATA_O(q),
    .RVALID_O(rv), .WATCHDOG_EVENT_FLAG_O(wf));
  sdsr_master u_sdsr_master(.clk_i(c), .rvalid_i(rv), .rdata_i(q),
    .rd_o(rd), .addr_o(ad));
  task rc(input [2:0] a, input [7:0] e);
    u_sdsr_master.rd(a, d);
    total_checks++;
    if (d !== e) begin
      num_errors++;
      $display("mismatch %0t read %h", $time, d);
    end
  endtask
  task cf(input e);
    @(negedge c);
    total_checks++;
    if (wf !== e) begin
      num_errors++;
      $display("mismatch %0t flag %b", $time, wf);
    end
  endtask
  task t_rst;
    for (i = 0; i < 8; i++) rc(i[2:0], 8'h00);
    $display("t_rst end");
  endtask
  task t_flags;
    @(negedge c) f = 20'hf0303;
    rc(3'h4, 8'h6c);
    rc(3'h7, 8'h81);
    @(negedge c) f = 20'h0;
    rc(3'h5, 8'hc0);
    rc(3'h6, 8'h0c);
    rc(3'h5, 8'h00);
    $display("t_flags end");
  endtask
  task t_wd;
    @(negedge c) wt = 1;
    rc(3'h4, 8'h90);
    @(negedge c) {wt, wr, wb} = 3'h3;
    rc(3'h4, 8'h90);
    @(negedge c) {wt, wr, wb} = 3'h6;
    cf(1'b1);
    @(negedge c) {wt, wr, wb} = 3'h2;
    rc(3'h4, 8'h00);
    cf(1'b0);
    $display("t_wd end");
  endtask
  task t_hrst;
    @(negedge c) {wt, wr, f} = {2'b10, 20'h00001};
    @(negedge c) {wt, f} = 21'h0;
    r = 0;
    repeat (2) @(negedge c);
    r = 1;
    cf(1'b0);
    rc(3'h6, 8'h00);
    rc(3'h4, 8'h00);
    $display("t_hrst end");
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge c);
    r = 1;
    t_rst;
    t_flags;
    t_wd;
    t_hrst;
    print_verdict;
  end
  initial begin
    #9000 num_errors++;
    print_verdict;
  end
endmodule // sdsr_status_regs_tb
